// ==== rtl/cpu_regs_core.sv ====
`timescale 1ns/1ns
module cpu_regs_core
  import cpu_regs_pkg::*;
#(
  parameter int PORT_BITS = 16
) (
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 arst_n_i,
  // RAM space access
  input  wire logic [RAM_AW-1:0]    ram_addr_i,
  input  wire logic                 ram_rd_i,
  input  wire logic                 ram_wr_i,
  input  wire logic [DIG_W-1:0]     ram_wdata_i,
  input  wire logic                 bit_set_i,
  input  wire logic                 bit_clr_i,
  input  wire logic [1:0]           bit_sel_i,
  output logic      [DIG_W-1:0]     ram_rdata_o,
  // Working registers
  input  wire logic                 cpu_we_i,
  input  wire logic [2:0]           cpu_sel_i,
  input  wire logic [DIG_W-1:0]     cpu_wdata_i,
  output logic      [DIG_W-1:0]     acc_o,
  output logic      [DIG_W-1:0]     aux_data_o,
  output logic      [1:0]           ind_addr_hi_o,
  output logic      [DIG_W-1:0]     ind_addr_mid_o,
  output logic      [DIG_W-1:0]     ind_addr_lo_o,
  output logic      [DIG_W-1:0]     aux_ptr_one_o,
  output logic      [DIG_W-1:0]     aux_ptr_two_o,
  // Flags
  input  wire logic                 ovf_we_i,
  input  wire logic                 ovf_i,
  input  wire logic                 cond_we_i,
  input  wire logic                 cond_i,
  input  wire logic                 cond_force_i,
  output logic                      alu_overflow_bit_o,
  output logic                      cond_flag_o,
  // Program counter and stack
  input  wire logic                 pc_load_i,
  input  wire logic [PC_W-1:0]      pc_value_i,
  input  wire logic                 pc_step_i,
  input  wire logic                 call_push_i,
  input  wire logic                 irq_entry_i,
  input  wire logic                 sub_return_i,
  input  wire logic                 irq_return_i,
  output logic      [PC_W-1:0]      pc_o,
  output logic      [RAM_AW-1:0]    push_pointer_o,
  output logic                      stack_busy_o,
  // Interrupt bits
  input  wire logic [NSRC-1:0]      irq_src_i,
  output logic                      irq_global_on_o,
  output logic      [NSRC-1:0]      irq_pending_o,
  output logic      [NSRC-1:0]      irq_mask_bit_o,
  // Loose flags
  input  wire logic                 subactive_i,
  output logic                      slow_clock_on_o,
  output logic                      dog_timer_on_o,
  output logic                      tone_rate_sel_o,
  output logic                      direct_xfer_on_o,
  // Port pins
  input  wire logic                 port_we_i,
  input  wire logic [PORT_BITS-1:0] port_wdata_i,
  input  wire logic                 drive_we_i,
  input  wire logic [PORT_BITS-1:0] drive_wdata_i,
  output logic      [PORT_BITS-1:0] port_out_value_o,
  output logic      [PORT_BITS-1:0] port_drive_on_o,
  output logic      [PORT_BITS-1:0] pin_out_o,
  output logic      [PORT_BITS-1:0] pin_oe_n_o,
  // Peripheral configuration
  input  wire logic                 cfg_we_i,
  input  wire logic [4:0]           cfg_sel_i,
  input  wire logic [CFG_DW-1:0]    cfg_wdata_i,
  output logic      [3:0]           port_cfg_a_o,
  output logic      [3:0]           port_cfg_b_o,
  output logic      [3:0]           tmr_cfg_a_o,
  output logic      [3:0]           tmr_cfg_b_o,
  output logic      [3:0]           tmr_cfg_c_o,
  output logic      [3:0]           ser_cfg_o,
  output logic      [10:0]          prescaler_s_o,
  output logic      [7:0]           prescaler_w_o,
  output logic      [7:0]           cnt_a_value_o,
  output logic      [7:0]           cnt_b_value_o,
  output logic      [7:0]           cnt_c_value_o,
  output logic      [7:0]           reload_b_o,
  output logic      [7:0]           reload_c_o,
  output logic      [2:0]           octal_cnt_o,
  output logic      [2:0]           lcd_ctrl_o,
  output logic      [3:0]           lcd_duty_cfg_o,
  output logic      [2:0]           tone_ctrl_o,
  output logic      [3:0]           tone_cfg_o,
  output logic      [2:0]           extra_cfg_o
);
  logic [1:0]         rst_sync_reg;
  logic               rst_n;
  seq_t               seq_reg;
  logic [1:0]         cnt_reg;
  logic               restore_reg;
  logic [11:0]        pop_buf_reg;
  logic [SPL_W-1:0]   spl_reg;
  logic [PC_W-1:0]    pc_reg;
  logic               ca_reg;
  logic               st_reg;
  logic [3:0]         bank_reg;
  logic               ie_reg;
  logic [NSRC-1:0]    pend_reg;
  logic [NSRC-1:0]    mask_reg;
  logic [3:0]         flags_reg;
  logic               rd_special_reg;
  logic [DIG_W-1:0]   special_reg;
  logic [DIG_W-1:0]   mem_rdata;
  logic               mem_we;
  logic [PHYS_AW-1:0] mem_addr;
  logic [DIG_W-1:0]   mem_wdata;
  logic [RAM_AW-1:0]  stk_addr;
  logic [DIG_W-1:0]   push_digit;
  logic               busy;
  logic               ext_ok;
  logic               in_bank;
  logic               special;
  logic               in_irq;
  logic               in_flag;
  logic [3:0]         bset;
  logic [3:0]         bclr;
  logic [DIG_W-1:0]   special_rd;
  logic [CFG_DW-1:0]  cfg_q [CFG_N];

  // Reset release through two flops
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  assign busy   = (seq_reg != SEQ_IDLE);
  assign ext_ok = rst_n && !busy;

  // Address decode
  assign in_bank = (ram_addr_i >= BANK_LO) && (ram_addr_i <= BANK_HI);
  assign in_irq  = (ram_addr_i <= IRQ_AREA_LAST);
  assign in_flag = (ram_addr_i == FLAG_AREA_ADDR);
  assign special = in_irq || in_flag || (ram_addr_i == BANK_SEL_ADDR);

  // Bit operation strobes per bit of the addressed digit
  always_comb begin
    bset = 4'h0;
    bclr = 4'h0;
    if (ext_ok && bit_set_i) begin
      bset[bit_sel_i] = 1'b1;
    end
    if (ext_ok && bit_clr_i) begin
      bclr[bit_sel_i] = 1'b1;
    end
  end

  // Stack digit address and data
  always_comb begin
    stk_addr = {SP_TOP, spl_reg - {4'h0, cnt_reg}};
    if (seq_reg == SEQ_POP) begin
      stk_addr = {SP_TOP, spl_reg + (SP_STEP - {4'h0, cnt_reg})};
    end
    case (cnt_reg)
      2'h0:    push_digit = pc_reg[3:0];
      2'h1:    push_digit = pc_reg[7:4];
      2'h2:    push_digit = pc_reg[11:8];
      default: push_digit = {ca_reg, st_reg, pc_reg[13:12]};
    endcase
  end

  // Memory port: stack sequencer owns it while busy
  always_comb begin
    mem_we    = 1'b0;
    mem_wdata = ram_wdata_i;
    mem_addr  = {1'b0, stk_addr};
    if (busy) begin
      mem_we    = (seq_reg == SEQ_PUSH);
      mem_wdata = push_digit;
    end else begin
      mem_we   = ext_ok && ram_wr_i && !special;
      mem_addr = {in_bank && (bank_reg == BANK_ONE), ram_addr_i};
    end
  end

  ram_digits #(
    .AW (PHYS_AW),
    .DW (DIG_W)
  ) u_ram (
    .clk_i   (mclk_i),
    .we_i    (mem_we),
    .addr_i  (mem_addr),
    .wdata_i (mem_wdata),
    .rdata_o (mem_rdata)
  );

  // Read view of the mapped control digits
  always_comb begin
    special_rd = bank_reg;
    if (in_flag) begin
      special_rd = flags_reg;
    end else if (in_irq) begin
      special_rd = 4'h0;
      for (int i = 0; i < NSRC; i++) begin
        if (SRC_DIGIT[i] == ram_addr_i[1:0]) begin
          special_rd[SRC_PBIT[i]] = pend_reg[i];
          special_rd[SRC_MBIT[i]] = mask_reg[i];
        end
      end
      if (ram_addr_i[1:0] == 2'h0) begin
        special_rd[IE_BIT] = ie_reg;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_special_reg <= 1'b0;
      special_reg    <= 4'h0;
    end else if (ext_ok && ram_rd_i) begin
      rd_special_reg <= special;
      special_reg    <= special_rd;
    end
  end
  assign ram_rdata_o = rd_special_reg ? special_reg : mem_rdata;

  // Bank select register
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      bank_reg <= BANK_RESET;
    end else if (ext_ok && ram_wr_i && ram_addr_i == BANK_SEL_ADDR) begin
      bank_reg <= ram_wdata_i;
    end
  end

  // Working registers; all cleared to zero by reset
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      acc_o          <= 4'h0;
      aux_data_o     <= 4'h0;
      ind_addr_hi_o  <= 2'h0;
      ind_addr_mid_o <= 4'h0;
      ind_addr_lo_o  <= 4'h0;
      aux_ptr_one_o  <= 4'h0;
      aux_ptr_two_o  <= 4'h0;
    end else if (cpu_we_i) begin
      case (cpu_sel_i)
        SEL_ACC:  acc_o          <= cpu_wdata_i;
        SEL_AUXD: aux_data_o     <= cpu_wdata_i;
        SEL_HI:   ind_addr_hi_o  <= cpu_wdata_i[1:0];
        SEL_MID:  ind_addr_mid_o <= cpu_wdata_i;
        SEL_LO:   ind_addr_lo_o  <= cpu_wdata_i;
        SEL_PT1:  aux_ptr_one_o  <= cpu_wdata_i;
        SEL_PT2:  aux_ptr_two_o  <= cpu_wdata_i;
        default: ;
      endcase
    end
  end

  // Overflow and condition flags
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ca_reg <= 1'b0;
      st_reg <= COND_RESET;
    end else if (seq_reg == SEQ_POP_LAST && restore_reg) begin
      ca_reg <= mem_rdata[3];
      st_reg <= mem_rdata[2];
    end else begin
      if (ovf_we_i) begin
        ca_reg <= ovf_i;
      end
      if (cond_force_i) begin
        st_reg <= 1'b1;
      end else if (cond_we_i) begin
        st_reg <= cond_i;
      end
    end
  end

  // Stack sequencer, one digit per cycle
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      seq_reg     <= SEQ_IDLE;
      cnt_reg     <= 2'h0;
      restore_reg <= 1'b0;
      pop_buf_reg <= 12'h000;
    end else begin
      case (seq_reg)
        SEQ_IDLE: begin
          cnt_reg <= 2'h0;
          if (call_push_i || irq_entry_i) begin
            seq_reg <= SEQ_PUSH;
          end else if (sub_return_i || irq_return_i) begin
            seq_reg     <= SEQ_POP;
            restore_reg <= irq_return_i;
          end
        end
        SEQ_PUSH: begin
          cnt_reg <= cnt_reg + 2'h1;
          if (cnt_reg == 2'h3) begin
            seq_reg <= SEQ_IDLE;
          end
        end
        SEQ_POP: begin
          cnt_reg <= cnt_reg + 2'h1;
          if (cnt_reg != 2'h0) begin
            pop_buf_reg <= {mem_rdata, pop_buf_reg[11:4]};
          end
          if (cnt_reg == 2'h3) begin
            seq_reg <= SEQ_POP_LAST;
          end
        end
        SEQ_POP_LAST: begin
          seq_reg <= SEQ_IDLE;
        end
        default: seq_reg <= SEQ_IDLE;
      endcase
    end
  end
  assign stack_busy_o = busy;

  // Push pointer low bits; top bits are wired to ones
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      spl_reg <= SPL_RESET;
    end else if (seq_reg == SEQ_PUSH && cnt_reg == 2'h3) begin
      spl_reg <= spl_reg - SP_STEP;
    end else if (seq_reg == SEQ_POP_LAST) begin
      spl_reg <= spl_reg + SP_STEP;
    end else if (in_irq && ram_addr_i[1:0] == 2'h0 && bclr[RSP_BIT]) begin
      spl_reg <= SPL_RESET;
    end
  end
  assign push_pointer_o = {SP_TOP, spl_reg};

  // Program counter
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      pc_reg <= PC_RESET;
    end else if (seq_reg == SEQ_POP_LAST) begin
      pc_reg <= {mem_rdata[1:0], pop_buf_reg};
    end else if (!busy && pc_load_i) begin
      pc_reg <= pc_value_i;
    end else if (!busy && pc_step_i) begin
      pc_reg <= pc_reg + 14'h0001;
    end
  end
  assign pc_o = pc_reg;
  assign alu_overflow_bit_o = ca_reg;
  assign cond_flag_o = st_reg;

  // Interrupt control digits; hardware set beats software clear
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ie_reg   <= 1'b0;
      pend_reg <= PEND_RESET;
      mask_reg <= MASK_RESET;
    end else begin
      if (irq_entry_i && !busy) begin
        ie_reg <= 1'b0;
      end else if (seq_reg == SEQ_POP_LAST && restore_reg) begin
        ie_reg <= 1'b1;
      end else if (in_irq && ram_addr_i[1:0] == 2'h0) begin
        ie_reg <= (ie_reg | bset[IE_BIT]) & ~bclr[IE_BIT];
      end
      for (int i = 0; i < NSRC; i++) begin
        if (irq_src_i[i]) begin
          pend_reg[i] <= 1'b1;
        end else if (in_irq && ram_addr_i[1:0] == SRC_DIGIT[i]) begin
          pend_reg[i] <= pend_reg[i] & ~bclr[SRC_PBIT[i]];
        end
        if (in_irq && ram_addr_i[1:0] == SRC_DIGIT[i]) begin
          mask_reg[i] <= (mask_reg[i] | bset[SRC_MBIT[i]]) & ~bclr[SRC_MBIT[i]];
        end
      end
    end
  end
  assign irq_global_on_o = ie_reg;
  assign irq_pending_o   = pend_reg;
  assign irq_mask_bit_o  = mask_reg;

  // Loose flags; watchdog can only be set, transfer flag lives in subactive mode
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= 4'h0;
    end else begin
      if (in_flag) begin
        flags_reg[SLOW_CLOCK_ON_POS] <= (flags_reg[SLOW_CLOCK_ON_POS] | bset[SLOW_CLOCK_ON_POS]) & ~bclr[SLOW_CLOCK_ON_POS];
        flags_reg[DOG_TIMER_ON_POS] <= flags_reg[DOG_TIMER_ON_POS] | bset[DOG_TIMER_ON_POS];
        flags_reg[TONE_RATE_SEL_POS] <= (flags_reg[TONE_RATE_SEL_POS] | bset[TONE_RATE_SEL_POS]) & ~bclr[TONE_RATE_SEL_POS];
      end
      if (!subactive_i) begin
        flags_reg[DIRECT_XFER_ON_POS] <= 1'b0;
      end else if (in_flag) begin
        flags_reg[DIRECT_XFER_ON_POS] <= (flags_reg[DIRECT_XFER_ON_POS] | bset[DIRECT_XFER_ON_POS]) & ~bclr[DIRECT_XFER_ON_POS];
      end
    end
  end
  assign slow_clock_on_o  = flags_reg[SLOW_CLOCK_ON_POS];
  assign dog_timer_on_o   = flags_reg[DOG_TIMER_ON_POS];
  assign tone_rate_sel_o  = flags_reg[TONE_RATE_SEL_POS];
  assign direct_xfer_on_o = flags_reg[DIRECT_XFER_ON_POS];

  // Port data and drive enables; drivers off keeps pins floating
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      port_out_value_o <= '1;
      port_drive_on_o  <= '0;
    end else begin
      if (port_we_i) begin
        port_out_value_o <= port_wdata_i;
      end
      if (drive_we_i) begin
        port_drive_on_o <= drive_wdata_i;
      end
    end
  end
  assign pin_out_o  = port_out_value_o;
  assign pin_oe_n_o = ~port_drive_on_o;

  // Peripheral configuration slots
  for (genvar g = 0; g < CFG_N; g++) begin : g_cfg
    cfg_reg #(
      .W   (CFG_DW),
      .RST (CFG_RESET)
    ) u_cfg (
      .clk_i   (mclk_i),
      .rst_n_i (rst_n),
      .we_i    (cfg_we_i && cfg_sel_i == 5'(g)),
      .d_i     (cfg_wdata_i),
      .q_o     (cfg_q[g])
    );
  end
  assign port_cfg_a_o   = cfg_q[0][3:0];
  assign port_cfg_b_o   = cfg_q[1][3:0];
  assign tmr_cfg_a_o    = cfg_q[2][3:0];
  assign tmr_cfg_b_o    = cfg_q[3][3:0];
  assign tmr_cfg_c_o    = cfg_q[4][3:0];
  assign ser_cfg_o      = cfg_q[5][3:0];
  assign prescaler_s_o  = cfg_q[6][10:0];
  assign prescaler_w_o  = cfg_q[7][7:0];
  assign cnt_a_value_o  = cfg_q[8][7:0];
  assign cnt_b_value_o  = cfg_q[9][7:0];
  assign cnt_c_value_o  = cfg_q[10][7:0];
  assign reload_b_o     = cfg_q[11][7:0];
  assign reload_c_o     = cfg_q[12][7:0];
  assign octal_cnt_o    = cfg_q[13][2:0];
  assign lcd_ctrl_o     = cfg_q[14][2:0];
  assign lcd_duty_cfg_o = cfg_q[15][3:0];
  assign tone_ctrl_o    = cfg_q[16][2:0];
  assign tone_cfg_o     = cfg_q[17][3:0];
  assign extra_cfg_o    = cfg_q[18][2:0];
endmodule

// ==== rtl/cpu_regs_pkg.sv ====
package cpu_regs_pkg;
  localparam int DIG_W   = 4;
  localparam int RAM_AW  = 10;
  localparam int PHYS_AW = 11;
  localparam int PC_W    = 14;
  localparam int SPL_W   = 6;
  localparam int NSRC    = 6;
  localparam int CFG_N   = 19;
  localparam int CFG_DW  = 12;

  localparam logic [9:0] IRQ_AREA_ADDR  = 10'h000;
  localparam logic [9:0] IRQ_AREA_LAST  = 10'h003;
  localparam logic [9:0] FLAG_AREA_ADDR = 10'h020;
  localparam logic [9:0] BANK_SEL_ADDR  = 10'h03F;
  localparam logic [9:0] BANK_LO        = 10'h100;
  localparam logic [9:0] BANK_HI        = 10'h2CF;

  localparam logic [3:0]  BANK_RESET = 4'h0;
  localparam logic [3:0]  BANK_ONE   = 4'h1;
  localparam logic [13:0] PC_RESET   = 14'h0000;
  localparam logic [3:0]  SP_TOP     = 4'hF;
  localparam logic [5:0]  SPL_RESET  = 6'h3F;
  localparam logic [5:0]  SP_STEP    = 6'h04;
  localparam logic        COND_RESET = 1'b1;
  localparam logic [5:0]  MASK_RESET = 6'h3F;
  localparam logic [5:0]  PEND_RESET = 6'h00;

  // Bit positions inside the interrupt control and flag digits
  localparam int IE_BIT   = 0;
  localparam int RSP_BIT  = 1;
  localparam int SLOW_CLOCK_ON_POS = 0;
  localparam int DOG_TIMER_ON_POS = 1;
  localparam int TONE_RATE_SEL_POS = 2;
  localparam int DIRECT_XFER_ON_POS = 3;
  // Sources: ext0, ext1, timer a, timer b, timer c, serial
  localparam logic [1:0] SRC_DIGIT [NSRC] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
  localparam logic [1:0] SRC_PBIT  [NSRC] = '{2'h2, 2'h0, 2'h2, 2'h0, 2'h2, 2'h0};
  localparam logic [1:0] SRC_MBIT  [NSRC] = '{2'h3, 2'h1, 2'h3, 2'h1, 2'h3, 2'h1};

  // Internal register select codes
  localparam logic [2:0] SEL_ACC  = 3'h0;
  localparam logic [2:0] SEL_AUXD = 3'h1;
  localparam logic [2:0] SEL_HI   = 3'h2;
  localparam logic [2:0] SEL_MID  = 3'h3;
  localparam logic [2:0] SEL_LO   = 3'h4;
  localparam logic [2:0] SEL_PT1  = 3'h5;
  localparam logic [2:0] SEL_PT2  = 3'h6;

  // Peripheral configuration slots, all clear after reset
  localparam int CFG_W [CFG_N] = '{4, 4, 4, 4, 4, 4, 11, 8, 8, 8, 8, 8, 8, 3, 3, 4, 3, 4, 3};
  localparam logic [CFG_DW-1:0] CFG_RESET = 12'h000;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_PUSH, SEQ_POP, SEQ_POP_LAST} seq_t;
endpackage

// ==== rtl/ram_digits.sv ====
`timescale 1ns/1ns
module ram_digits #(
  parameter int AW = 11,
  parameter int DW = 4
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);
  // No reset: contents survive a reset that ends stop mode
  logic [DW-1:0] mem_reg [2**AW];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_reg[addr_i] <= wdata_i;
    end
    rdata_o <= mem_reg[addr_i];
  end
endmodule

// ==== rtl/cfg_reg.sv ====
`timescale 1ns/1ns
module cfg_reg #(
  parameter int         W   = 4,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         we_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_o <= RST;
    end else if (we_i) begin
      q_o <= d_i;
    end
  end
endmodule

// ==== bench/rst_source.sv ====
`timescale 1ns/1ns
module rst_source #(
  parameter int HOLD = 2
) (
  // Clock and request
  input  wire logic mclk_i,
  input  wire logic req_i,
  // Reset line
  output logic      arst_n_o
);
  // Low at power-on, again for HOLD cycles on each request
  initial begin
    arst_n_o = 1'b0;
    forever begin
      repeat (HOLD) @(posedge mclk_i);
      #1 arst_n_o = 1'b1;
      @(posedge req_i);
      #1 arst_n_o = 1'b0;
    end
  end
endmodule

// ==== bench/cpu_regs_chk_sva.sv ====
`timescale 1ns/1ns
module cpu_regs_chk #(
  parameter int PORT_BITS = 16
) (
  // Clock and reset
  input wire logic                 mclk_i,
  input wire logic                 arst_n_i,
  // Requests
  input wire logic [9:0]           ram_addr_i,
  input wire logic                 ram_rd_i,
  input wire logic                 ram_wr_i,
  input wire logic [3:0]           ram_wdata_i,
  input wire logic                 bit_clr_i,
  input wire logic [1:0]           bit_sel_i,
  input wire logic                 cond_force_i,
  input wire logic                 call_push_i,
  input wire logic                 irq_entry_i,
  input wire logic                 sub_return_i,
  input wire logic                 irq_return_i,
  // Results
  input wire logic [3:0]           ram_rdata_o,
  input wire logic                 cond_flag_o,
  input wire logic [13:0]          pc_o,
  input wire logic [9:0]           push_pointer_o,
  input wire logic                 stack_busy_o,
  input wire logic                 irq_global_on_o,
  input wire logic [5:0]           irq_pending_o,
  input wire logic [5:0]           irq_mask_bit_o,
  input wire logic [PORT_BITS-1:0] port_out_value_o,
  input wire logic [PORT_BITS-1:0] pin_oe_n_o
);
  logic [1:0] up_reg;
  logic       ok;
  // Requests before the synchronised release are ignored
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      up_reg <= 2'h0;
    end else if (up_reg != 2'h3) begin
      up_reg <= up_reg + 2'h1;
    end
  end
  assign ok = up_reg[1] && !stack_busy_o;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_push; (call_push_i || irq_entry_i) && ok; endsequence
  sequence s_pop; (sub_return_i || irq_return_i) && !call_push_i && !irq_entry_i && ok; endsequence
  sequence s_bank;
    ram_wr_i && ram_addr_i == 10'h03F && ok ##2 ram_rd_i && ram_addr_i == 10'h03F && ok;
  endsequence
  property p_rst_vals;
    $rose(arst_n_i) |-> pc_o == 14'h0000 && cond_flag_o && !irq_global_on_o
      && irq_pending_o == 6'h00 && &irq_mask_bit_o && push_pointer_o == 10'h3FF;
  endproperty
  property p_rst_pins; $rose(arst_n_i) |-> &port_out_value_o && &pin_oe_n_o; endproperty
  property p_sp_top; push_pointer_o[9:6] == 4'hF; endproperty
  property p_push;
    s_push |=> stack_busy_o [*4] ##1 !stack_busy_o && push_pointer_o == $past(push_pointer_o, 5) - 10'h004;
  endproperty
  property p_pop;
    s_pop |=> stack_busy_o [*5] ##1 !stack_busy_o && push_pointer_o == $past(push_pointer_o, 6) + 10'h004;
  endproperty
  property p_bank; s_bank |=> ram_rdata_o == $past(ram_wdata_i, 3); endproperty
  property p_force; cond_force_i && ok |=> cond_flag_o; endproperty
  property p_reinit;
    bit_clr_i && ram_addr_i == 10'h000 && bit_sel_i == 2'h1 && ok |=> push_pointer_o == 10'h3FF;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
  a_rst_pins: assert property (p_rst_pins) else $error("pins not released");
  a_sp_top: assert property (p_sp_top) else $error("pointer top bits");
  a_push: assert property (p_push) else $error("push step wrong");
  a_pop: assert property (p_pop) else $error("pop step wrong");
  a_bank: assert property (p_bank) else $error("bank readback wrong");
  a_force: assert property (p_force) else $error("flag not forced");
  a_reinit: assert property (p_reinit) else $error("pointer not reloaded");
endmodule
bind cpu_regs_core cpu_regs_chk #(.PORT_BITS(PORT_BITS)) u_cpu_regs_chk (.*);

// ==== bench/tb.sv ====
`timescale 1ns/1ns
module tb;
  logic mclk_i = 1'b0;
  logic arst_n_i, rst_req, ram_rd_i, ram_wr_i, bit_set_i, bit_clr_i, cpu_we_i, port_we_i;
  logic drive_we_i, cfg_we_i, subactive_i, call_push_i, irq_entry_i, sub_return_i, irq_return_i;
  logic cond_force_i, cond_we_i, cond_i, ovf_we_i, ovf_i, pc_step_i, pc_load_i, cond_flag_o;
  logic alu_overflow_bit_o, stack_busy_o, irq_global_on_o, slow_clock_on_o, dog_timer_on_o;
  logic tone_rate_sel_o, direct_xfer_on_o;
  logic [1:0] bit_sel_i, ind_addr_hi_o;
  logic [2:0] cpu_sel_i, octal_cnt_o, lcd_ctrl_o, tone_ctrl_o, extra_cfg_o;
  logic [3:0] ram_wdata_i, cpu_wdata_i, ram_rdata_o, acc_o, aux_data_o, ind_addr_mid_o;
  logic [3:0] ind_addr_lo_o, aux_ptr_one_o, aux_ptr_two_o, port_cfg_a_o, port_cfg_b_o;
  logic [3:0] tmr_cfg_a_o, tmr_cfg_b_o, tmr_cfg_c_o, ser_cfg_o, lcd_duty_cfg_o, tone_cfg_o;
  logic [4:0] cfg_sel_i;
  logic [5:0] irq_src_i, irq_pending_o, irq_mask_bit_o;
  logic [7:0] prescaler_w_o, cnt_a_value_o, cnt_b_value_o, cnt_c_value_o, reload_b_o, reload_c_o;
  logic [9:0] ram_addr_i, push_pointer_o;
  logic [10:0] prescaler_s_o, ctl;
  logic [11:0] cfg_wdata_i;
  logic [13:0] pc_value_i, pc_o;
  logic [15:0] port_wdata_i, drive_wdata_i, port_out_value_o, port_drive_on_o, pin_out_o, pin_oe_n_o;
  logic [3:0] stk [4] = '{4'hD, 4'hB, 4'hA, 4'hA};
  int bad_count = 0;
  int n_compared = 0;
  assign {call_push_i, irq_entry_i, sub_return_i, irq_return_i, cond_force_i, cond_we_i, cond_i,
          ovf_we_i, ovf_i, pc_step_i, pc_load_i} = ctl;
  always #20 mclk_i = ~mclk_i;
  rst_source u_rst_source (.mclk_i(mclk_i), .req_i(rst_req), .arst_n_o(arst_n_i));
  cpu_regs_core u_cpu_regs_core (.*);
  task step; @(posedge mclk_i); #1; endtask
  task chk(input logic [63:0] g, input logic [63:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %0t got %h exp %h", $time, g, e);
    end
  endtask
  task ram(input logic w, input logic [9:0] a, input logic [3:0] d);
    ram_addr_i = a; ram_wdata_i = d; ram_wr_i = w; ram_rd_i = !w; step;
    ram_wr_i = 1'b0; ram_rd_i = 1'b0;
    if (!w) chk(ram_rdata_o, d);
    step;
  endtask
  task bop(input logic s, input logic c, input logic [1:0] b, input logic [9:0] a);
    ram_addr_i = a; bit_sel_i = b; bit_set_i = s; bit_clr_i = c; step;
    bit_set_i = 1'b0; bit_clr_i = 1'b0; step;
  endtask
  // Stack ops keep busy for several cycles; wait is bounded
  task pulse(input logic [10:0] v);
    ctl = v; step;
    ctl = 11'h000; step;
    for (int k = 0; k < 8 && stack_busy_o !== 1'b0; k++) step;
    chk(stack_busy_o, 1'b0);
  endtask
  task rchk;
    wait (arst_n_i === 1'b1);
    repeat (2) step;
    chk({pc_o, cond_flag_o, irq_global_on_o, irq_pending_o}, {14'h0000, 2'h2, 6'h00});
    chk({irq_mask_bit_o, push_pointer_o}, {6'h3F, 10'h3FF});
    chk({port_out_value_o, pin_oe_n_o, port_drive_on_o}, {32'hFFFFFFFF, 16'h0000});
    chk(|{port_cfg_a_o, port_cfg_b_o, tmr_cfg_a_o, tmr_cfg_b_o, tmr_cfg_c_o, ser_cfg_o, prescaler_s_o,
          prescaler_w_o, cnt_a_value_o, cnt_b_value_o, cnt_c_value_o, reload_b_o, reload_c_o,
          octal_cnt_o}, 1'b0);
    chk(|{lcd_ctrl_o, lcd_duty_cfg_o, tone_ctrl_o, tone_cfg_o, extra_cfg_o, slow_clock_on_o,
          dog_timer_on_o, tone_rate_sel_o, direct_xfer_on_o}, 1'b0);
    ram(1'b0, 10'h03F, 4'h0);
  endtask
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #40000;
    bad_count++;
    complete_run;
  end
  initial begin
    {ram_rd_i, ram_wr_i, bit_set_i, bit_clr_i, cpu_we_i, port_we_i, drive_we_i, cfg_we_i, subactive_i,
     irq_src_i, cfg_sel_i, cfg_wdata_i, ram_addr_i, ram_wdata_i, bit_sel_i, cpu_sel_i, cpu_wdata_i,
     pc_value_i, port_wdata_i, drive_wdata_i} = '0;
    ctl = 11'h000;
    rst_req = 1'b0;
    rchk;
    ram(1'b1, 10'h100, 4'h5);
    ram(1'b1, 10'h050, 4'h3);
    ram(1'b1, 10'h03F, 4'h1);
    ram(1'b0, 10'h03F, 4'h1);
    ram(1'b1, 10'h100, 4'hA);
    ram(1'b1, 10'h3C0, 4'h7);
    ram(1'b0, 10'h100, 4'hA);
    ram(1'b0, 10'h050, 4'h3);
    ram(1'b1, 10'h03F, 4'h0);
    ram(1'b0, 10'h100, 4'h5);
    ram(1'b0, 10'h3C0, 4'h7);
    cpu_we_i = 1'b1;
    for (int i = 0; i < 7; i++) begin
      cpu_sel_i = 3'(i);
      cpu_wdata_i = 4'(i + 8);
      step;
    end
    cpu_we_i = 1'b0;
    chk({acc_o, aux_data_o, ind_addr_hi_o, ind_addr_mid_o, ind_addr_lo_o, aux_ptr_one_o, aux_ptr_two_o},
        {8'h89, 2'h2, 16'hBCDE});
    pc_value_i = 14'h2ABC;
    pulse(11'h02D);
    chk({pc_o, cond_flag_o, alu_overflow_bit_o}, {14'h2ABC, 2'h1});
    pulse(11'h002);
    chk({pc_o, cond_flag_o}, {14'h2ABD, 1'b0});
    bop(1'b1, 1'b0, 2'h0, 10'h000);
    pulse(11'h200);
    chk({push_pointer_o, irq_global_on_o}, {10'h3FB, 1'b0});
    for (int k = 0; k < 4; k++) ram(1'b0, 10'(10'h3FF - k), stk[k]);
    pc_value_i = 14'h0000;
    pulse(11'h049);
    chk({cond_flag_o, alu_overflow_bit_o}, 2'h2);
    pulse(11'h080);
    chk({pc_o, cond_flag_o, alu_overflow_bit_o, push_pointer_o, irq_global_on_o},
        {14'h2ABD, 2'h1, 10'h3FF, 1'b1});
    pulse(11'h400);
    pulse(11'h049);
    pulse(11'h100);
    chk({pc_o, cond_flag_o, alu_overflow_bit_o}, {14'h2ABD, 2'h2});
    pulse(11'h400);
    bop(1'b0, 1'b1, 2'h1, 10'h000);
    chk(push_pointer_o, 10'h3FF);
    port_we_i = 1'b1; port_wdata_i = 16'h5A5A; drive_we_i = 1'b1; drive_wdata_i = 16'h00FF; step;
    port_we_i = 1'b0; drive_we_i = 1'b0; step;
    chk({pin_out_o, pin_oe_n_o}, {16'h5A5A, 16'hFF00});
    bop(1'b1, 1'b0, 2'h1, 10'h020);
    cfg_we_i = 1'b1; cfg_sel_i = 5'h06; cfg_wdata_i = 12'h7FF; irq_src_i = 6'h3F; step;
    cfg_we_i = 1'b0; irq_src_i = 6'h00;
    bop(1'b0, 1'b1, 2'h3, 10'h000);
    chk({dog_timer_on_o, prescaler_s_o, irq_pending_o, irq_mask_bit_o},
        {12'hFFF, 6'h3F, 6'h3E});
    rst_req = 1'b1; step;
    rst_req = 1'b0;
    rchk;
    ram(1'b0, 10'h100, 4'h5);
    complete_run;
  end
endmodule
